// ### logic/afmt_map.svh
// Register offsets, field positions, reset values and timing figures of the formatter
`ifndef AFMT_MAP_SVH
`define AFMT_MAP_SVH

// ==========================================================================
// Register byte offsets
`define AFMT_CHAN_OFS      6'h00
`define AFMT_CFG_OFS       6'h20
`define AFMT_STAT_OFS      6'h24
`define AFMT_MASK_OFS      6'h28
`define AFMT_CAL_OFS       6'h2c

// ==========================================================================
// Configuration fields
`define AFMT_CFG_EIGHT     0
`define AFMT_CFG_RNG_A_LO  1
`define AFMT_CFG_RNG_B_LO  4
`define AFMT_CFG_FMT_A     7
`define AFMT_CFG_FMT_B     8
`define AFMT_CFG_RST       9'h001

// ==========================================================================
// Output word and status fields
`define AFMT_WORD_OOR      15
`define AFMT_WORD_ZERO     14
`define AFMT_EV_SCAN       0
`define AFMT_EV_OOR        1
`define AFMT_EV_CAL        2
`define AFMT_EV_CFGERR     3

// ==========================================================================
// Count limits
`define AFMT_RAW_MAX       14'sh1068
`define AFMT_RAW_FULL      13'h1000
`define AFMT_DEC_MAX_0_10  14'h270f

// ==========================================================================
// Timing
`define AFMT_CLK_NS        40
`define AFMT_SCAN4_NS      2400000
`define AFMT_SCAN8_NS      3000000

`endif

// ### logic/afmt_pkg.sv
// Types shared by the analog input data formatter
package afmt_pkg;

    // ======================================================================
    // Input ranges
    typedef enum logic [2:0] {
        RNG_0_5,
        RNG_0_10,
        RNG_1_5,
        RNG_PM10,
        RNG_PM5
    } range_t;

    // ======================================================================
    // Configuration and samples
    typedef struct packed {
        logic        fmt_b;
        logic        fmt_a;
        logic [2:0]  range_b;
        logic [2:0]  range_a;
        logic        eight;
    } cfg_t;

    typedef struct packed {
        logic [2:0]  chan;
        logic        oor;
        logic [12:0] raw;
    } sample_t;

    typedef struct packed {
        logic        oor;
        logic        zero;
        logic [13:0] data;
    } out_word_t;

endpackage

// ### logic/analog_input_data_formatter.sv
// Digital side of the eight channel analog input module
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "afmt_map.svh"
module analog_input_data_formatter #(
    parameter int SCAN4_CYC   = `AFMT_SCAN4_NS / `AFMT_CLK_NS,
    parameter int SCAN8_CYC   = `AFMT_SCAN8_NS / `AFMT_CLK_NS,
    parameter int AVG_LEN     = 4,
    parameter int CAL_NOMINAL = 4000,
    parameter int CAL_TOL     = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // Avalon-MM slave
    input  wire logic [5:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [31:0]  avs_writedata_i,
    output logic [31:0]       avs_readdata_o,
    output logic              avs_waitrequest_o,
    // Converter
    output logic              conv_start_o,
    output logic [2:0]        conv_chan_o,
    output logic              conv_ref_o,
    input  wire logic         conv_done_i,
    input  wire logic [13:0]  conv_code_i,
    // Calibration trim
    output logic              cal_up_o,
    output logic              cal_dn_o,
    // Indicators and interrupt
    output logic              oor_led_o,
    output logic              irq_o
);

    localparam int AW = (AVG_LEN > 1) ? $clog2(AVG_LEN) : 1;
    localparam int SW = 13 + AW;
    // The average divides by a shift, so the window length must be a power of two
    localparam int SH = $clog2(AVG_LEN);
    localparam logic [16:0] SLOT4 = 17'(SCAN4_CYC / 4 - 1);
    localparam logic [16:0] SLOT8 = 17'(SCAN8_CYC / 8 - 1);

    typedef enum logic [1:0] {S_WAIT, S_CONV, S_REF} sched_t;

    function automatic logic grp_of(input logic [2:0] ch, input logic eight);
        grp_of = eight ? ch[2] : ch[1];
    endfunction

    function automatic logic is_bipolar(input logic [2:0] rng);
        is_bipolar = (rng == 3'(afmt_pkg::RNG_PM10)) || (rng == 3'(afmt_pkg::RNG_PM5));
    endfunction

    // ======================================================================
    // Register bus
    afmt_pkg::cfg_t  cfg_ff, nxt_cfg;
    logic [3:0]      stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic            ack_ff, nxt_ack;
    logic [31:0]     rdata_ff, nxt_rdata;
    logic [15:0]     cal_cnt_ff, nxt_cal_cnt;
    logic [15:0]     words_ff [8];
    logic [3:0]      ev;
    logic            cfg_err;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
    assign avs_readdata_o    = rdata_ff;
    assign cfg_err = (cfg_ff.fmt_a & is_bipolar(cfg_ff.range_a))
                   | (cfg_ff.fmt_b & is_bipolar(cfg_ff.range_b))
                   | (cfg_ff.range_a > 3'(afmt_pkg::RNG_PM5))
                   | (cfg_ff.range_b > 3'(afmt_pkg::RNG_PM5));

    always_comb begin
        nxt_ack   = (avs_read_i | avs_write_i) & ~ack_ff;
        nxt_cfg   = cfg_ff;
        nxt_mask  = mask_ff;
        nxt_stat  = stat_ff;
        nxt_rdata = rdata_ff;
        if (nxt_ack && avs_read_i) begin
            nxt_rdata = 32'h0000_0000;
            if (avs_address_i < `AFMT_CFG_OFS)
                nxt_rdata = {16'h0000, words_ff[avs_address_i[4:2]]};
            case (avs_address_i[5:2])
                4'h8: nxt_rdata = {23'h000000, cfg_ff};
                4'h9: nxt_rdata = {28'h0000000, stat_ff};
                4'ha: nxt_rdata = {28'h0000000, mask_ff};
                4'hb: nxt_rdata = {16'h0000, cal_cnt_ff};
                default: ;
            endcase
        end
        if (ack_ff && avs_write_i) begin
            case (avs_address_i[5:2])
                4'h8: nxt_cfg = afmt_pkg::cfg_t'(avs_writedata_i[8:0]);
                4'h9: nxt_stat = stat_ff & ~avs_writedata_i[3:0];
                4'ha: nxt_mask = avs_writedata_i[3:0];
                default: ;
            endcase
        end
        // A new event outranks a clear in the same cycle
        nxt_stat = nxt_stat | ev;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_ff   <= afmt_pkg::cfg_t'(`AFMT_CFG_RST);
            stat_ff  <= 4'h0;
            mask_ff  <= 4'h0;
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            cfg_ff   <= nxt_cfg;
            stat_ff  <= nxt_stat;
            mask_ff  <= nxt_mask;
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign irq_o = |(stat_ff & mask_ff);

    // ======================================================================
    // Conversion scheduler
    // A slot that ticks while a conversion is still running stays pending
    sched_t       st_ff, nxt_st;
    logic [16:0]  tmr_ff, nxt_tmr;
    logic         pend_ff, nxt_pend;
    logic [2:0]   chan_ff, nxt_chan;
    logic         start_ff, nxt_start, ref_ff, nxt_ref;
    logic         tick;
    logic [2:0]   last_ch;

    assign tick    = (tmr_ff == 17'h00000);
    assign last_ch = cfg_ff.eight ? 3'h7 : 3'h3;

    always_comb begin
        nxt_tmr   = tick ? (cfg_ff.eight ? SLOT8 : SLOT4) : tmr_ff - 17'h00001;
        nxt_pend  = pend_ff | tick;
        nxt_st    = st_ff;
        nxt_chan  = chan_ff;
        nxt_start = 1'b0;
        nxt_ref   = ref_ff;
        case (st_ff)
            S_WAIT: begin
                if (pend_ff) begin
                    nxt_pend  = tick;
                    nxt_start = 1'b1;
                    nxt_ref   = 1'b0;
                    nxt_st    = S_CONV;
                    // A switch to four circuits can leave the index past the last channel
                    if (chan_ff > last_ch)
                        nxt_chan = 3'h0;
                end
            end
            S_CONV: begin
                if (conv_done_i && !start_ff) begin
                    if (chan_ff >= last_ch) begin
                        nxt_chan  = 3'h0;
                        nxt_start = 1'b1;
                        nxt_ref   = 1'b1;
                        nxt_st    = S_REF;
                    end else begin
                        nxt_chan = chan_ff + 3'h1;
                        nxt_st   = S_WAIT;
                    end
                end
            end
            S_REF: begin
                if (conv_done_i && !start_ff)
                    nxt_st = S_WAIT;
            end
            default: nxt_st = S_WAIT;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff    <= S_WAIT;
            tmr_ff   <= 17'h00000;
            pend_ff  <= 1'b0;
            chan_ff  <= 3'h0;
            start_ff <= 1'b0;
            ref_ff   <= 1'b0;
        end else if (ce_i) begin
            st_ff    <= nxt_st;
            tmr_ff   <= nxt_tmr;
            pend_ff  <= nxt_pend;
            chan_ff  <= nxt_chan;
            start_ff <= nxt_start;
            ref_ff   <= nxt_ref;
        end
    end

    assign conv_start_o = start_ff;
    assign conv_chan_o  = chan_ff;
    assign conv_ref_o   = ref_ff;

    // ======================================================================
    // Background calibration
    logic  cal_up_ff, nxt_cal_up, cal_dn_ff, nxt_cal_dn;
    logic  ref_done;

    assign ref_done = (st_ff == S_REF) && conv_done_i && !start_ff;

    always_comb begin
        nxt_cal_up  = 1'b0;
        nxt_cal_dn  = 1'b0;
        nxt_cal_cnt = cal_cnt_ff;
        if (ref_done) begin
            // Trim only outside the dead band so noise does not hunt
            if (int'(conv_code_i) > CAL_NOMINAL + CAL_TOL)
                nxt_cal_dn = 1'b1;
            else if (int'(conv_code_i) < CAL_NOMINAL - CAL_TOL)
                nxt_cal_up = 1'b1;
            if (nxt_cal_up || nxt_cal_dn)
                nxt_cal_cnt = cal_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_up_ff  <= 1'b0;
            cal_dn_ff  <= 1'b0;
            cal_cnt_ff <= 16'h0000;
        end else if (ce_i) begin
            cal_up_ff  <= nxt_cal_up;
            cal_dn_ff  <= nxt_cal_dn;
            cal_cnt_ff <= nxt_cal_cnt;
        end
    end

    assign cal_up_o = cal_up_ff;
    assign cal_dn_o = cal_dn_ff;

    // ======================================================================
    // Clamp and moving average
    // History starts at zero, so the first AVG_LEN samples ramp up from 0
    logic [12:0]     hist_ff [8][AVG_LEN];
    logic            hoor_ff [8][AVG_LEN];
    logic [AW-1:0]   ptr_ff  [8];
    logic [SW-1:0]   sum_ff  [8];
    logic [AW:0]     ocnt_ff [8];
    logic            s1_valid_ff, nxt_s1_valid;
    afmt_pkg::sample_t s1_ff, nxt_s1;
    logic            chan_done, smp_oor;
    logic [12:0]     smp_raw;
    logic [SW-1:0]   nxt_sum;
    logic [AW:0]     nxt_ocnt;
    logic signed [13:0] code;

    assign chan_done = (st_ff == S_CONV) && conv_done_i && !start_ff;
    assign code      = signed'(conv_code_i);

    always_comb begin
        // Converter code is already the place within the span, 0 at range bottom
        smp_raw = conv_code_i[12:0];
        smp_oor = 1'b0;
        if (code < 14'sh0000) begin
            smp_raw = 13'h0000;
            smp_oor = 1'b1;
        end else if (code > `AFMT_RAW_MAX) begin
            smp_raw = 13'(`AFMT_RAW_MAX);
            smp_oor = 1'b1;
        end
        nxt_sum  = sum_ff[chan_ff] + SW'(smp_raw) - SW'(hist_ff[chan_ff][ptr_ff[chan_ff]]);
        nxt_ocnt = ocnt_ff[chan_ff] + (AW+1)'(smp_oor)
                 - (AW+1)'(hoor_ff[chan_ff][ptr_ff[chan_ff]]);
        nxt_s1_valid = chan_done;
        nxt_s1       = s1_ff;
        if (chan_done) begin
            nxt_s1.chan = chan_ff;
            nxt_s1.raw  = 13'(nxt_sum >> SH);
            nxt_s1.oor  = (nxt_ocnt != '0);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_valid_ff <= 1'b0;
            s1_ff       <= '0;
            for (int c = 0; c < 8; c++) begin
                ptr_ff[c]  <= '0;
                sum_ff[c]  <= '0;
                ocnt_ff[c] <= '0;
                for (int k = 0; k < AVG_LEN; k++) begin
                    hist_ff[c][k] <= 13'h0000;
                    hoor_ff[c][k] <= 1'b0;
                end
            end
        end else if (ce_i) begin
            s1_valid_ff <= nxt_s1_valid;
            s1_ff       <= nxt_s1;
            if (chan_done) begin
                hist_ff[chan_ff][ptr_ff[chan_ff]] <= smp_raw;
                hoor_ff[chan_ff][ptr_ff[chan_ff]] <= smp_oor;
                // Wrap at the window length so the history index never leaves the array
                ptr_ff[chan_ff]  <= (int'(ptr_ff[chan_ff]) == AVG_LEN - 1) ? '0
                                  : AW'(ptr_ff[chan_ff] + 1'b1);
                sum_ff[chan_ff]  <= nxt_sum;
                ocnt_ff[chan_ff] <= nxt_ocnt;
            end
        end
    end

    // ======================================================================
    // Formatting and output words
    logic               sc_valid, sc_sat, s1_grp, sc_grp, use_dec;
    afmt_pkg::sample_t  sc_smp;
    logic [13:0]        sc_dec;
    afmt_pkg::out_word_t wd;

    assign s1_grp = grp_of(s1_ff.chan, cfg_ff.eight);

    decimal_scaler u_scaler (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .valid_i (s1_valid_ff),
        .smp_i   (s1_ff),
        .range_i (s1_grp ? cfg_ff.range_b : cfg_ff.range_a),
        .valid_o (sc_valid),
        .smp_o   (sc_smp),
        .dec_o   (sc_dec),
        .sat_o   (sc_sat)
    );

    always_comb begin
        sc_grp  = grp_of(sc_smp.chan, cfg_ff.eight);
        // Bipolar ranges fall back to raw count, decimal has no sign
        use_dec = sc_grp ? (cfg_ff.fmt_b & ~is_bipolar(cfg_ff.range_b))
                         : (cfg_ff.fmt_a & ~is_bipolar(cfg_ff.range_a));
        wd.zero = 1'b0;
        wd.oor  = sc_smp.oor | (use_dec & sc_sat);
        wd.data = use_dec ? sc_dec : {1'b0, sc_smp.raw};
        ev = 4'h0;
        ev[`AFMT_EV_SCAN]   = sc_valid && (sc_smp.chan == last_ch);
        ev[`AFMT_EV_OOR]    = chan_done && smp_oor;
        ev[`AFMT_EV_CAL]    = cal_up_ff | cal_dn_ff;
        ev[`AFMT_EV_CFGERR] = cfg_err;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < 8; c++)
                words_ff[c] <= 16'h0000;
        end else if (ce_i && sc_valid) begin
            words_ff[sc_smp.chan] <= wd;
        end
    end

    always_comb begin
        oor_led_o = 1'b0;
        for (int c = 0; c < 8; c++)
            oor_led_o = oor_led_o | words_ff[c][`AFMT_WORD_OOR];
    end

    // ======================================================================
    // Checks
    default clocking cb_chk @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_hi_sample;
        ce_i && chan_done && (code > `AFMT_RAW_MAX);
    endsequence

    sequence seq_ref_high;
        ce_i && ref_done && (int'(conv_code_i) > CAL_NOMINAL + CAL_TOL);
    endsequence

    a_start_one_cycle: assert property (ce_i && start_ff |=> !start_ff)
        else $error("conversion start longer than one cycle");
    a_chan_in_group: assert property (start_ff && !ref_ff |-> chan_ff <= last_ch)
        else $error("conversion started on inactive channel");
    a_clamp_high: assert property (seq_hi_sample |=> s1_ff.oor && s1_valid_ff)
        else $error("over range sample not flagged");
    a_clamp_low: assert property (ce_i && chan_done && code < 14'sh0000 |=> s1_ff.oor)
        else $error("under range sample not flagged");
    a_margin_ok: assert property (ce_i && chan_done && !code[13] && code <= `AFMT_RAW_MAX
                                  && ocnt_ff[chan_ff] == '0
                                  && !hoor_ff[chan_ff][ptr_ff[chan_ff]] |=> !s1_ff.oor)
        else $error("margin sample flagged");
    a_word_status: assert property (ce_i && sc_valid |=> words_ff[$past(sc_smp.chan)][14] == 1'b0
                                    && words_ff[$past(sc_smp.chan)][15] == $past(wd.oor))
        else $error("output word status bits wrong");
    a_cal_trim_dn: assert property (seq_ref_high |=> cal_dn_ff && !cal_up_ff ##1 !cal_dn_ff)
        else $error("calibration trim not issued once");
    a_raw_limit: assert property (s1_valid_ff |-> s1_ff.raw <= 13'(`AFMT_RAW_MAX))
        else $error("raw count above limit");
    a_bus_wait: assert property (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
                                 |=> !avs_waitrequest_o)
        else $error("bus access not answered in one cycle");

endmodule

// ### logic/decimal_scaler.sv
// Registered conversion of a raw count into a decimal voltmeter reading
`timescale 1ns/10ps
module decimal_scaler (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    // Input sample
    input  wire logic            valid_i,
    input  wire afmt_pkg::sample_t smp_i,
    input  wire logic [2:0]      range_i,
    // Registered result
    output logic                 valid_o,
    output afmt_pkg::sample_t    smp_o,
    output logic [13:0]          dec_o,
    output logic                 sat_o
);

    // ======================================================================
    // Scaling
    logic                valid_ff, nxt_valid;
    afmt_pkg::sample_t   smp_ff, nxt_smp;
    logic [13:0]         dec_ff, nxt_dec;
    logic                sat_ff, nxt_sat;
    logic [25:0]         prod;
    logic [13:0]         full_scale_span;
    logic [13:0]         base;
    logic [13:0]         scaled;

    always_comb begin
        full_scale_span = 14'h1388;
        base            = 14'h0000;
        case (afmt_pkg::range_t'(range_i))
            afmt_pkg::RNG_0_10: full_scale_span = 14'h2710;
            afmt_pkg::RNG_1_5: begin
                full_scale_span = 14'h0fa0;
                base            = 14'h03e8;
            end
            default: full_scale_span = 14'h1388;
        endcase
        // Round to nearest so a full 4200 count reads 5127 on 0 to 5
        prod      = 26'(smp_i.raw) * 26'(full_scale_span) + 26'h0000800;
        scaled    = 14'(prod[25:12]) + base;
        nxt_sat   = 1'b0;
        nxt_dec   = scaled;
        if (afmt_pkg::range_t'(range_i) == afmt_pkg::RNG_0_10
                && scaled > `AFMT_DEC_MAX_0_10) begin
            // Four digits cannot show 10.000 V
            nxt_dec = `AFMT_DEC_MAX_0_10;
            nxt_sat = 1'b1;
        end
        nxt_valid = valid_i;
        nxt_smp   = smp_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_ff <= 1'b0;
            smp_ff   <= '0;
            dec_ff   <= 14'h0000;
            sat_ff   <= 1'b0;
        end else if (ce_i) begin
            valid_ff <= nxt_valid;
            smp_ff   <= nxt_smp;
            dec_ff   <= nxt_dec;
            sat_ff   <= nxt_sat;
        end
    end

    assign valid_o = valid_ff;
    assign smp_o   = smp_ff;
    assign dec_o   = dec_ff;
    assign sat_o   = sat_ff;

endmodule

// ### test/conv_model.sv
// Behavioural converter on the far side of the formatter
`timescale 1ns/10ps
module conv_model (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Requests from the formatter
    input  wire logic             start_i,
    input  wire logic             ref_i,
    input  wire logic [2:0]       chan_i,
    // Field values and answer delay
    input  wire logic [7:0][13:0] codes_i,
    input  wire logic [13:0]      ref_code_i,
    input  wire logic [3:0]       dly_i,
    // Answer
    output logic                  done_o,
    output logic [13:0]           code_o
);
    int          cnt;
    logic [13:0] res;
    // ======================================================================
    // Code lines toggle outside the answer cycle so nothing stale is read
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt    <= 0;
            done_o <= 1'b0;
            code_o <= 14'h0;
        end else begin
            done_o <= 1'b0;
            code_o <= ~code_o;
            if (start_i) begin
                cnt <= int'(dly_i) + 1;
                res <= ref_i ? ref_code_i : codes_i[chan_i];
            end else if (cnt == 1) begin
                done_o <= 1'b1;
                code_o <= res;
                cnt    <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// ### test/test_analog_input_data_formatter.sv
// Self-checking bench for the analog input data formatter
`timescale 1ns/10ps
module test_analog_input_data_formatter;
    logic clk_i = 0, rst_i = 1, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic [5:0] avs_address_i = 6'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic avs_waitrequest_o, conv_start_o, conv_ref_o, conv_done_i, cal_up_o, cal_dn_o;
    logic oor_led_o, irq_o;
    logic [2:0] conv_chan_o;
    logic [13:0] conv_code_i;
    logic [7:0][13:0] codes = '0;
    logic [3:0] dly = 4'h0;
    logic [63:0] q[$];
    int failures = 0, n_tests = 0, seed = 32'hb3cc;
    int c1[8], c2[4];
    // ======================================================================
    // Design and converter
    analog_input_data_formatter #(.SCAN4_CYC(400), .SCAN8_CYC(800), .AVG_LEN(1)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .conv_start_o(conv_start_o),
        .conv_chan_o(conv_chan_o), .conv_ref_o(conv_ref_o), .conv_done_i(conv_done_i),
        .conv_code_i(conv_code_i), .cal_up_o(cal_up_o), .cal_dn_o(cal_dn_o),
        .oor_led_o(oor_led_o), .irq_o(irq_o));
    conv_model cm (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o), .ref_i(conv_ref_o),
        .chan_i(conv_chan_o), .codes_i(codes), .ref_code_i(14'h0faa), .dly_i(dly),
        .done_o(conv_done_i), .code_o(conv_code_i));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) dly <= 4'($random(seed));
    // Reference reads high, so an upward trim is never due
    always @(posedge clk_i) if (!rst_i && cal_up_o !== 1'b0) cmp({31'h0, cal_up_o}, 32'h0);
    // ======================================================================
    // Scoreboard: oldest note against each completed read
    task cmp(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, a, e);
        end
    endtask
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && q.size() > 0) begin
            cmp(avs_readdata_o & q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
        end
    end
    task bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task chk(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        q.push_back({m, e});
        bus(0, a, 32'h0);
    endtask
    // Expected word from a converter code, decimal only on unipolar ranges
    function automatic logic [31:0] ex(int c, bit dec, int rng);
        int r, d, f;
        f = (c < 0 || c > 4200);
        r = c < 0 ? 0 : (c > 4200 ? 4200 : c);
        d = r;
        if (dec && rng < 3) begin
            d = (r * (rng == 0 ? 5000 : rng == 1 ? 10000 : 4000) + 2048) / 4096;
            d = d + (rng == 2 ? 1000 : 0);
            if (d > 9999) begin
                d = 9999;
                f = 1;
            end
        end
        return {16'h0, f[0], 1'b0, d[13:0]};
    endfunction
    // Clear the flags and wait for the next completed scan
    task scan(input int lim);
        int n;
        bus(1, 6'h24, 32'hf);
        n = 0;
        while (irq_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) cmp({31'h0, irq_o}, 32'h1);
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #240000;
        failures++;
        report_and_stop;
    end
    // ======================================================================
    // Main sequence
    initial begin
        c1 = '{-5, 4201, 4200, $unsigned($random(seed)) % 4201, 4096, 4200, 0, 1024};
        c2 = '{4100, 2048, 4200, $unsigned($random(seed)) % 4201};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(6'h20, 32'h1);
        chk(6'h00, 32'h0);
        bus(1, 6'h30, 32'hffff);
        chk(6'h30, 32'h0);
        for (int i = 0; i < 8; i++) codes[i] <= c1[i][13:0];
        bus(1, 6'h20, 32'h121);
        bus(1, 6'h28, 32'h1);
        scan(860);
        scan(860);
        for (int i = 0; i < 8; i++) chk(6'(i * 4), ex(c1[i], i > 3, i > 3 ? 2 : 0));
        cmp({31'h0, oor_led_o}, 32'h1);
        chk(6'h24, 32'h7, 32'h7);
        bus(1, 6'h28, 32'h0);
        cmp({31'h0, irq_o}, 32'h0);
        for (int i = 0; i < 4; i++) codes[i] <= c2[i][13:0];
        bus(1, 6'h20, 32'h1b2);
        bus(1, 6'h28, 32'h1);
        scan(460);
        scan(460);
        for (int i = 0; i < 4; i++) chk(6'(i * 4), ex(c2[i], 1, i < 2 ? 1 : 3));
        chk(6'h24, 32'h8, 32'h8);
        report_and_stop;
    end
endmodule
